// ---- include/pkt_gen_consts.vh ----
`ifndef PKT_GEN_CONSTS_VH
`define PKT_GEN_CONSTS_VH

// ==========================================================
// Register byte offsets
`define OFS_CTRL 8'h10
`define OFS_COUNTS 8'h14
`define OFS_CHECK 8'h18
`define OFS_GAP 8'h1C
`define OFS_IRQ_STAT 8'h20
`define OFS_IRQ_CLR 8'h24
`define OFS_IRQ_EN 8'h28

// ==========================================================
// Control and check register fields
`define BIT_ERRORED 0
`define BIT_LONG 1
`define BIT_PATTERN 2
`define BIT_GEN_EN 3
`define BIT_CHK_EN 4
`define BIT_KEEP_EN 6
`define BIT_TRIGGER 7
`define BURST_HI 15
`define BURST_LO 8
`define BIT_CNT_CLR 4

// ==========================================================
// Interrupt status bits
`define IRQ_BURST_DONE 0
`define IRQ_RX_FRAME 1
`define IRQ_RX_CRC_ERR 2

// ==========================================================
// Reset values and frame figures
`define GAP_RESET 8'h0C
`define BURST_RESET 8'h00
`define PAYLOAD_SHORT 11'd60
`define PAYLOAD_LONG 11'd1514
`define PREAMBLE_BYTE 8'h55
`define SFD_BYTE 8'hD5
`define PATTERN_EVEN 8'h5A
`define PATTERN_ODD 8'hA5
`define CRC_INIT 32'hFFFFFFFF
`define CRC_RESIDUE 32'hDEBB20E3
`define LFSR_SEED 16'hACE1
`define COUNT_MAX 8'hFF

`endif

// ---- rtl/crc32_byte_step.v ----
`default_nettype none

// ==========================================================
// Reflected CRC-32 advanced by one byte, LSB first
module crc32_byte_step (
	// Running remainder and new byte
	input wire [31:0] crc_in,
	input wire [7:0] byte_in,
	// Remainder after the byte
	output wire [31:0] crc_out
);
	wire [31:0] stage [0:8];

	assign stage[0] = crc_in;

	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_bit
			assign stage[i+1] = (stage[i][0] ^ byte_in[i]) ?
				({1'b0, stage[i][31:1]} ^ 32'hEDB88320) : {1'b0, stage[i][31:1]};
		end
	endgenerate

	assign crc_out = stage[8];
endmodule

`default_nettype wire

// ---- rtl/pkt_gen_top.v ----
// The Avalon-MM register port was chosen for this implementation.
`include "pkt_gen_consts.vh"
`default_nettype none

module pkt_gen_top (
	// Clock and reset
	input wire mclk,
	input wire sys_rst,
	// Avalon-MM slave
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	// Transmit byte stream toward the copper path
	output reg [7:0] tx_data,
	output reg tx_en,
	output reg tx_er,
	// Receive byte stream from the copper path
	input wire [7:0] rx_data,
	input wire rx_dv,
	input wire rx_er,
	// Interrupt
	output reg irq
);
	localparam ST_IDLE = 3'd0;
	localparam ST_PRE = 3'd1;
	localparam ST_DATA = 3'd2;
	localparam ST_FCS = 3'd3;
	localparam ST_GAP = 3'd4;

	// ==========================================================
	// Configuration and burst state
	reg [7:0] burst_r;
	reg keep_r, chk_r, gen_en_r, pat_r, long_r, err_r;
	reg done_r, burst_act_r;
	reg [7:0] sent_r;
	reg [7:0] gap_r;
	reg [2:0] irq_stat_r, irq_en_r;
	reg [7:0] pkt_cnt_r, err_cnt_r;

	// ==========================================================
	// Generator state
	reg [2:0] state_r;
	reg [10:0] cnt_r;
	reg [31:0] tx_crc_r;
	reg [15:0] lfsr_r;

	// ==========================================================
	// Checker state
	reg rx_in_r, rx_bad_r;
	reg [31:0] rx_crc_r;

	// ==========================================================
	// Bus access decode
	wire wr_acc = avs_write && !avs_waitrequest;
	wire wr_ctrl = wr_acc && (avs_address == `OFS_CTRL);
	wire wr_check = wr_acc && (avs_address == `OFS_CHECK);
	wire wr_gap = wr_acc && (avs_address == `OFS_GAP) && avs_byteenable[0];
	wire wr_iclr = wr_acc && (avs_address == `OFS_IRQ_CLR) && avs_byteenable[0];
	wire wr_ien = wr_acc && (avs_address == `OFS_IRQ_EN) && avs_byteenable[0];
	wire lo_be = avs_byteenable[0];
	wire hi_be = avs_byteenable[1];

	// New enable value that a control write would store
	wire new_en = lo_be ? avs_writedata[`BIT_GEN_EN] : gen_en_r;
	wire en_rise = wr_ctrl && !gen_en_r && new_en;
	// Retrigger: only from the done state, with the three qualifiers met
	wire retrig = wr_ctrl && lo_be && done_r && !avs_writedata[`BIT_TRIGGER]
		&& keep_r && gen_en_r && (burst_r != 8'h00);

	// ==========================================================
	// Frame sequencing terms
	wire [10:0] pay_len = long_r ? `PAYLOAD_LONG : `PAYLOAD_SHORT;
	wire go = gen_en_r && ((burst_r == 8'h00) || burst_act_r);
	wire frame_end = (state_r == ST_GAP) && (cnt_r[7:0] == gap_r);
	wire last_frame = (burst_r != 8'h00) && (sent_r + 8'h01 == burst_r);
	wire burst_done = frame_end && burst_act_r && last_frame;

	wire [7:0] pay_byte = pat_r ? (cnt_r[0] ? `PATTERN_ODD : `PATTERN_EVEN)
		: lfsr_r[7:0];
	// A true FCS is the inverted remainder; sending it raw guarantees a bad CRC
	wire [31:0] fcs = err_r ? tx_crc_r : ~tx_crc_r;
	reg [7:0] fcs_byte;
	wire [31:0] tx_crc_nxt;
	wire [31:0] rx_crc_nxt;

	always @* begin
		case (cnt_r[1:0])
			2'd0: fcs_byte = fcs[7:0];
			2'd1: fcs_byte = fcs[15:8];
			2'd2: fcs_byte = fcs[23:16];
			default: fcs_byte = fcs[31:24];
		endcase
	end

	crc32_byte_step u_tx_crc (
		.crc_in(tx_crc_r),
		.byte_in(pay_byte),
		.crc_out(tx_crc_nxt)
	);

	crc32_byte_step u_rx_crc (
		.crc_in(rx_crc_r),
		.byte_in(rx_data),
		.crc_out(rx_crc_nxt)
	);

	// ==========================================================
	// Control register and burst bookkeeping
	always @(posedge mclk) begin
		if (sys_rst) begin
			burst_r <= `BURST_RESET;
			keep_r <= 1'b0;
			chk_r <= 1'b0;
			gen_en_r <= 1'b0;
			pat_r <= 1'b0;
			long_r <= 1'b0;
			err_r <= 1'b0;
			done_r <= 1'b0;
			burst_act_r <= 1'b0;
			sent_r <= 8'h00;
			gap_r <= `GAP_RESET;
			irq_en_r <= 3'h0;
		end else begin
			if (frame_end && burst_act_r) begin
				sent_r <= sent_r + 8'h01;
			end
			if (burst_done) begin
				burst_act_r <= 1'b0;
				done_r <= 1'b1;
				if (!keep_r) begin
					gen_en_r <= 1'b0;
				end
			end
			if (wr_ctrl) begin
				if (lo_be) begin
					keep_r <= avs_writedata[`BIT_KEEP_EN];
					chk_r <= avs_writedata[`BIT_CHK_EN];
					gen_en_r <= avs_writedata[`BIT_GEN_EN];
					pat_r <= avs_writedata[`BIT_PATTERN];
					long_r <= avs_writedata[`BIT_LONG];
					err_r <= avs_writedata[`BIT_ERRORED];
				end
				if (hi_be) begin
					burst_r <= avs_writedata[`BURST_HI:`BURST_LO];
				end
				if (lo_be && !avs_writedata[`BIT_GEN_EN]) begin
					burst_act_r <= 1'b0;
				end
			end
			// A software launch overrides completion in the same cycle
			if (en_rise || retrig) begin
				burst_act_r <= 1'b1;
				sent_r <= 8'h00;
				done_r <= 1'b0;
			end
			if (wr_gap) begin
				gap_r <= avs_writedata[7:0];
			end
			if (wr_ien) begin
				irq_en_r <= avs_writedata[2:0];
			end
		end
	end

	// ==========================================================
	// Transmit sequencer
	always @(posedge mclk) begin
		if (sys_rst) begin
			state_r <= ST_IDLE;
			cnt_r <= 11'd0;
			tx_crc_r <= `CRC_INIT;
			lfsr_r <= `LFSR_SEED;
			tx_data <= 8'h00;
			tx_en <= 1'b0;
			tx_er <= 1'b0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					tx_en <= 1'b0;
					tx_er <= 1'b0;
					tx_data <= 8'h00;
					cnt_r <= 11'd0;
					if (go) begin
						state_r <= ST_PRE;
					end
				end
				ST_PRE: begin
					tx_en <= 1'b1;
					tx_er <= 1'b0;
					tx_data <= (cnt_r == 11'd7) ? `SFD_BYTE : `PREAMBLE_BYTE;
					tx_crc_r <= `CRC_INIT;
					if (cnt_r == 11'd7) begin
						state_r <= ST_DATA;
						cnt_r <= 11'd0;
					end else begin
						cnt_r <= cnt_r + 11'd1;
					end
				end
				ST_DATA: begin
					tx_en <= 1'b1;
					tx_data <= pay_byte;
					tx_er <= err_r && (cnt_r == 11'd0);
					tx_crc_r <= tx_crc_nxt;
					lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
					if (cnt_r == pay_len - 11'd1) begin
						state_r <= ST_FCS;
						cnt_r <= 11'd0;
					end else begin
						cnt_r <= cnt_r + 11'd1;
					end
				end
				ST_FCS: begin
					tx_en <= 1'b1;
					tx_er <= 1'b0;
					tx_data <= fcs_byte;
					if (cnt_r == 11'd3) begin
						state_r <= ST_GAP;
						cnt_r <= 11'd0;
					end else begin
						cnt_r <= cnt_r + 11'd1;
					end
				end
				ST_GAP: begin
					tx_en <= 1'b0;
					tx_er <= 1'b0;
					tx_data <= 8'h00;
					// Gap lasts gap_r + 1 byte times before the next preamble
					if (frame_end) begin
						cnt_r <= 11'd0;
						if (go && !(burst_act_r && last_frame)) begin
							state_r <= ST_PRE;
						end else begin
							state_r <= ST_IDLE;
						end
					end else begin
						cnt_r <= cnt_r + 11'd1;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Receive CRC checker and counters
	wire rx_end = rx_in_r && !rx_dv;
	wire rx_fail = rx_bad_r || (rx_crc_r != `CRC_RESIDUE);
	wire ev_frame = rx_end && chk_r;
	wire ev_err = ev_frame && rx_fail;

	always @(posedge mclk) begin
		if (sys_rst) begin
			rx_in_r <= 1'b0;
			rx_bad_r <= 1'b0;
			rx_crc_r <= `CRC_INIT;
			pkt_cnt_r <= 8'h00;
			err_cnt_r <= 8'h00;
		end else begin
			if (rx_dv && !rx_in_r && (rx_data == `SFD_BYTE)) begin
				rx_in_r <= 1'b1;
				rx_bad_r <= 1'b0;
				rx_crc_r <= `CRC_INIT;
			end else if (rx_dv && rx_in_r) begin
				rx_crc_r <= rx_crc_nxt;
				rx_bad_r <= rx_bad_r | rx_er;
			end else if (rx_end) begin
				rx_in_r <= 1'b0;
			end
			// Counters saturate rather than wrap
			if (ev_frame && pkt_cnt_r != `COUNT_MAX) begin
				pkt_cnt_r <= pkt_cnt_r + 8'h01;
			end
			if (ev_err && err_cnt_r != `COUNT_MAX) begin
				err_cnt_r <= err_cnt_r + 8'h01;
			end
			// The clear bit is never stored, so it reads back as zero
			if (wr_check && lo_be && avs_writedata[`BIT_CNT_CLR]) begin
				pkt_cnt_r <= 8'h00;
				err_cnt_r <= 8'h00;
			end
		end
	end

	// ==========================================================
	// Interrupt status, set wins over clear
	wire [2:0] irq_set = {ev_err, ev_frame, burst_done};
	wire [2:0] irq_stat_nxt = (irq_stat_r & ~(wr_iclr ? avs_writedata[2:0] : 3'h0))
		| irq_set;

	always @(posedge mclk) begin
		if (sys_rst) begin
			irq_stat_r <= 3'h0;
			irq <= 1'b0;
		end else begin
			irq_stat_r <= irq_stat_nxt;
			irq <= |(irq_stat_nxt & irq_en_r);
		end
	end

	// ==========================================================
	// Read mux and waitrequest: one wait cycle per access
	reg [31:0] rd_mux;

	always @* begin
		rd_mux = 32'h00000000;
		if (avs_address == `OFS_CTRL) begin
			rd_mux = {16'h0000, burst_r, done_r, keep_r, 1'b0, chk_r,
				gen_en_r, pat_r, long_r, err_r};
		end else if (avs_address == `OFS_COUNTS) begin
			rd_mux = {16'h0000, pkt_cnt_r, err_cnt_r};
		end else if (avs_address == `OFS_GAP) begin
			rd_mux = {24'h000000, gap_r};
		end else if (avs_address == `OFS_IRQ_STAT) begin
			rd_mux = {29'h0, irq_stat_r};
		end else if (avs_address == `OFS_IRQ_EN) begin
			rd_mux = {29'h0, irq_en_r};
		end
	end

	always @(posedge mclk) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
		end else if ((avs_read || avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
			avs_readdata <= rd_mux;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end
endmodule

`default_nettype wire

// ---- sim/pkt_gen_top_asserts.sv ----
`default_nettype none
// ==========
// Port checker for the test frame generator
module pkt_gen_asserts (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Register bus
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Transmit stream and interrupt
	input wire logic [7:0] tx_data,
	input wire logic tx_en,
	input wire logic tx_er,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// Bytes of the current frame; cleared in gaps so each frame is judged alone
	logic [10:0] on_r;
	always @(posedge mclk) begin
		if (sys_rst || !tx_en) begin
			on_r <= 11'h000;
		end else begin
			on_r <= on_r + 11'h001;
		end
	end
	property p_wait_pulse;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_wait_pulse: assert property (p_wait_pulse) else $error("wait low too long");
	property p_wait_answer;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_wait_answer: assert property (p_wait_answer) else $error("no bus answer");
	property p_rst_idle;
		$past(sys_rst) |-> avs_waitrequest && !tx_en && !tx_er && !irq;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle");
	property p_unmapped;
		avs_read && avs_waitrequest && avs_address == 8'h3C |=> avs_readdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	property p_preamble;
		$rose(tx_en) |-> (tx_data == 8'h55) [*7] ##1 tx_data == 8'hD5;
	endproperty
	a_preamble: assert property (p_preamble) else $error("bad preamble");
	property p_frame_len;
		$fell(tx_en) |-> on_r == 11'h048 || on_r == 11'h5F6;
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("bad frame length");
	property p_err_in_frame;
		tx_er |-> tx_en;
	endproperty
	a_err_in_frame: assert property (p_err_in_frame) else $error("stray error");
	property p_err_first;
		tx_er |-> $past(tx_en) && $past(tx_data) == 8'hD5;
	endproperty
	a_err_first: assert property (p_err_first) else $error("error misplaced");
endmodule
bind pkt_gen_top pkt_gen_asserts chk_u (.mclk(mclk), .sys_rst(sys_rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tx_data(tx_data),
	.tx_en(tx_en), .tx_er(tx_er), .irq(irq));
`default_nettype wire

// ---- sim/link_partner.sv ----
`default_nettype none
// ==========
// Far end that echoes every frame back and records what it saw
module link_partner (
	// Clock
	input wire logic mclk,
	// Stream from the block
	input wire logic [7:0] tx_data,
	input wire logic tx_en,
	input wire logic tx_er,
	// Echo toward the block
	output logic [7:0] rx_data,
	output logic rx_dv,
	output logic rx_er
);
	timeunit 1ns;
	timeprecision 1ns;
	int frames = 0;
	int len = 0;
	int pos = 0;
	int idle = 0;
	int gap = 0;
	logic [7:0] b0, b1;
	initial begin
		rx_data = 8'h00;
		rx_dv = 1'b0;
		rx_er = 1'b0;
	end
	always @(posedge mclk) begin
		rx_dv <= tx_en;
		// Idle line never repeats the last byte, so a stale read cannot pass
		rx_data <= tx_en ? tx_data : ~rx_data;
		rx_er <= tx_en & tx_er;
		if (tx_en) begin
			if (pos == 0) gap <= idle;
			if (pos == 8) b0 <= tx_data;
			if (pos == 9) b1 <= tx_data;
			pos <= pos + 1;
			idle <= 0;
		end else begin
			if (pos != 0) frames <= frames + 1;
			if (pos != 0) len <= pos;
			pos <= 0;
			idle <= idle + 1;
		end
	end
endmodule
`default_nettype wire

// ---- sim/pkt_gen_top_tb.sv ----
`include "pkt_gen_consts.vh"
`default_nettype none
module pkt_gen_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, r;
	logic avs_waitrequest, tx_en, tx_er, rx_dv, rx_er, irq;
	logic [7:0] tx_data, rx_data;
	logic [15:0] c;
	int num_errors = 0;
	int samples_checked = 0;
	int f0, i, k;
	// ==========
	// Rows: control word, gap field, bytes per frame
	logic [15:0] row_ctrl [3] = '{16'h021C, 16'h025E, 16'h0319};
	logic [7:0] row_gap [3] = '{8'h02, 8'h00, 8'h0C};
	int row_len [3] = '{72, 1526, 72};
	always #25 mclk = ~mclk;
	pkt_gen_top dut_u (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.tx_data(tx_data), .tx_en(tx_en), .tx_er(tx_er), .rx_data(rx_data), .rx_dv(rx_dv),
		.rx_er(rx_er), .irq(irq));
	link_partner lp_u (.mclk(mclk), .tx_data(tx_data), .tx_en(tx_en), .tx_er(tx_er),
		.rx_data(rx_data), .rx_dv(rx_dv), .rx_er(rx_er));
	// ==========
	// Shared tasks
	task stop_test;
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task tmo;
		num_errors++;
		stop_test();
	endtask
	task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s expected %0h seen %0h", n, exp, seen);
		end
	endtask
	// Wait state and read data are taken at the rising edge that ends the wait
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		for (n = 0; n < 20; n++) begin
			@(posedge mclk);
			if (avs_waitrequest === 1'b0) break;
		end
		r = avs_readdata;
		if (n == 20) tmo();
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task wait_done;
		for (k = 0; k < 2000; k++) begin
			bus(1'b0, `OFS_CTRL, 32'h0);
			if (r[7] === 1'b1) break;
		end
		if (k == 2000) tmo();
	endtask
	// ==========
	// Main sequence
	initial begin
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		bus(1'b0, `OFS_CTRL, 32'h0);
		chk("ctrl", r, 32'h0);
		bus(1'b0, `OFS_GAP, 32'h0);
		chk("gap", r, 32'h0C);
		bus(1'b0, 8'h3C, 32'h0);
		chk("unmapped", r, 32'h0);
		$display("reset test done");
		for (i = 0; i < 3; i++) begin
			c = row_ctrl[i];
			bus(1'b1, `OFS_CTRL, 32'h0);
			bus(1'b1, `OFS_CHECK, 32'h10);
			bus(1'b1, `OFS_GAP, {24'h0, row_gap[i]});
			f0 = lp_u.frames;
			bus(1'b1, `OFS_CTRL, {16'h0, c});
			wait_done();
			chk("ctrl", r, {16'h0, c[6] ? c : c & 16'hFFF7} | 32'h80);
			chk("frames", lp_u.frames - f0, {24'h0, c[15:8]});
			chk("length", lp_u.len, row_len[i]);
			chk("gap", lp_u.gap, row_gap[i] + 1);
			if (c[2]) chk("payload", {lp_u.b0, lp_u.b1}, 32'h5AA5);
			bus(1'b0, `OFS_COUNTS, 32'h0);
			chk("counts", r, {16'h0, c[15:8], c[0] ? c[15:8] : 8'h00});
			$display("row %0d done", i);
		end
		chk("irq", irq, 32'h0);
		bus(1'b1, `OFS_IRQ_EN, 32'h1);
		bus(1'b1, `OFS_IRQ_STAT, 32'h0);
		@(negedge mclk);
		chk("irq", irq, 32'h1);
		bus(1'b1, `OFS_IRQ_CLR, 32'h1);
		repeat (2) @(negedge mclk);
		chk("irq", irq, 32'h0);
		$display("interrupt test done");
		bus(1'b1, `OFS_CTRL, 32'h0);
		bus(1'b1, `OFS_CTRL, 32'h014C);
		wait_done();
		f0 = lp_u.frames;
		bus(1'b1, `OFS_CTRL, 32'h014C);
		bus(1'b1, `OFS_CTRL, 32'h01CC);
		bus(1'b0, `OFS_CTRL, 32'h0);
		chk("busy", r[7], 32'h0);
		wait_done();
		chk("retrigger", lp_u.frames - f0, 32'h1);
		bus(1'b0, `OFS_COUNTS, 32'h0);
		chk("idle counts", r, 32'h0303);
		$display("retrigger test done");
		bus(1'b1, `OFS_CTRL, 32'h0);
		f0 = lp_u.frames;
		bus(1'b1, `OFS_CTRL, 32'h0018);
		for (k = 0; k < 3000 && lp_u.frames - f0 < 3; k++) @(posedge mclk);
		if (k == 3000) tmo();
		bus(1'b0, `OFS_CTRL, 32'h0);
		chk("continuous", r[7:3], 32'h3);
		bus(1'b1, `OFS_CTRL, 32'h0);
		// Move the gap off its reset value so the reset below has to restore it
		bus(1'b1, `OFS_GAP, 32'h5);
		$display("continuous test done");
		sys_rst <= 1'b1;
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		bus(1'b0, `OFS_GAP, 32'h0);
		chk("gap", r, 32'h0C);
		bus(1'b0, `OFS_CTRL, 32'h0);
		chk("ctrl", r, 32'h0);
		bus(1'b0, `OFS_COUNTS, 32'h0);
		chk("counts", r, 32'h0);
		$display("second reset test done");
		stop_test();
	end
endmodule
`default_nettype wire
